// File: pkg/iefs_pkg.sv
package iefs_pkg;

  // ==========================================================================
  // Register map and field positions
  localparam logic [1:0] ADDR_IER  = 2'h0;
  localparam logic [1:0] ADDR_SR   = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;

  localparam int IER_TX_DONE_IE  = 6;
  localparam int IER_RX_IE       = 5;
  localparam int IER_NO_ACK_IE   = 4;
  localparam int IER_STOP_IE     = 3;
  localparam int IER_ACK_CHECK   = 2;
  localparam int IER_ACK_RECV    = 1;
  localparam int IER_ACK_TO_SEND = 0;

  localparam int SR_TX_EMPTY = 7;
  localparam int SR_TX_DONE  = 6;
  localparam int SR_RX_FULL  = 5;
  localparam int SR_NO_ACK   = 4;
  localparam int SR_STOP     = 3;
  localparam int SR_ARB_LOST = 2;

  localparam int CTRL_FORMAT = 0;
  localparam int CTRL_TX_SEL = 1;
  localparam int CTRL_MASTER = 2;

  localparam logic [7:0] IER_RESET  = 8'h00;
  localparam logic [7:0] SR_RESET   = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IER_WMASK  = 8'h7D;
  localparam logic [7:0] SR_FLAGS   = 8'hFC;
  localparam logic [7:0] CTRL_MASK  = 8'h07;

  // ==========================================================================
  // Frame bit counts
  localparam logic [3:0] CNT_FINAL = 4'h7;
  localparam logic [3:0] CNT_NINTH = 4'h8;
  localparam int         SYNC_W    = 2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic scl_rise;
    logic start;
    logic stop;
    logic final_rise;
    logic ninth_rise;
    logic ack_phase;
  } iefs_link_ev_type;

  typedef struct packed {
    logic tx_load;
    logic rx_load;
    logic start_issued;
    logic slave_to_tx;
    logic tx_holding_write;
    logic rx_holding_read;
    logic sda_drive;
  } iefs_dp_ev_type;

  typedef struct packed {
    logic rx_full_irq;
    logic error_irq;
    logic no_ack_irq;
    logic stop_irq;
    logic tx_done_irq;
  } iefs_irq_type;

endpackage

// File: src/iefs_sync2.sv
`timescale 1ns/1ns
module iefs_sync2
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // Pins in, synchronised out
  input  wire logic [iefs_pkg::SYNC_W-1:0] pin_in,
  output logic      [iefs_pkg::SYNC_W-1:0] pin_sync
);

  typedef struct packed {
    logic [iefs_pkg::SYNC_W-1:0] meta;
    logic [iefs_pkg::SYNC_W-1:0] stable;
  } iefs_sync_state_type;

  iefs_sync_state_type st;
  iefs_sync_state_type next_st;

  // ==========================================================================
  // First stage feeds only the second stage
  always_comb
  begin
    next_st        = st;
    next_st.meta   = pin_in;
    next_st.stable = st.meta;
  end

  // Idle bus level is high on both lines
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pin_sync = st.stable;

endmodule

// File: src/iefs_bus_watch.sv
`timescale 1ns/1ns
module iefs_bus_watch
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  // Synchronised lines and format
  input  wire logic                       scl_s,
  input  wire logic                       sda_s,
  input  wire logic                       format_select,
  // Detected bus events
  output iefs_pkg::iefs_link_ev_type      lev
);

  typedef struct packed {
    logic                       scl_d;
    logic                       sda_d;
    logic [3:0]                 cnt;
    iefs_pkg::iefs_link_ev_type ev;
  } iefs_watch_state_type;

  iefs_watch_state_type st;
  iefs_watch_state_type next_st;
  logic                 rise;
  logic                 fall;

  // ==========================================================================
  // Edge, condition and bit-count tracking
  always_comb
  begin
    next_st       = st;
    next_st.scl_d = scl_s;
    next_st.sda_d = sda_s;
    rise          = !st.scl_d && scl_s;
    fall          = st.scl_d && !scl_s;
    next_st.ev.scl_rise   = rise;
    next_st.ev.start      = !format_select && st.scl_d && scl_s && st.sda_d && !sda_s;
    next_st.ev.stop       = !format_select && st.scl_d && scl_s && !st.sda_d && sda_s;
    next_st.ev.final_rise = rise && (st.cnt == iefs_pkg::CNT_FINAL);
    next_st.ev.ninth_rise = rise && !format_select && (st.cnt == iefs_pkg::CNT_NINTH);
    if (next_st.ev.start)
    begin
      next_st.cnt = 4'h0;
    end
    else if (rise)
    begin
      // Clocked format frames are eight bits, two-wire frames nine
      if ((format_select && st.cnt == iefs_pkg::CNT_FINAL) ||
          st.cnt == iefs_pkg::CNT_NINTH)
      begin
        next_st.cnt = 4'h0;
      end
      else
      begin
        next_st.cnt = st.cnt + 4'h1;
      end
    end
    // Acknowledge slot spans from the eighth fall to the ninth fall
    if (fall && !format_select && st.cnt == iefs_pkg::CNT_NINTH)
    begin
      next_st.ev.ack_phase = 1'b1;
    end
    else if (fall || format_select || next_st.ev.start)
    begin
      next_st.ev.ack_phase = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st <= '{scl_d: 1'b1, sda_d: 1'b1, cnt: 4'h0, ev: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lev = st.ev;

endmodule

// File: src/iefs_flags.sv
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - Receive-full request when enabled; overrun error request in clocked format.
// - No-ack request on no-ack or arbitration-lost; overrun error request too.
// - Stop request only while the stop enable is set.
// - Ack check off ignores received ack; on, a received 1 halts transfer.
// - Transmit mode captures returned ack into a read-only bit.
// - Receive mode drives the ack-to-send value during the ack slot.
// - Tx-empty sets on load, transmit select, start issued, slave turn to transmit.
// - Tx-empty clears by write 0 after reading 1, or tx holding write.
// - Tx-done sets at ninth rise with tx-empty, or last clocked bit sent.
// - Tx-done clears by write 0 after reading 1, or tx holding write.
// - Rx-full sets on receive load; clears by write 0 after 1 or read.
// - No-ack flag sets when ack check is on and no ack returns.
// - Stop flag sets when a stop follows a frame transfer.
// - Master transmit: driven data differing from pin at clock rise loses arbitration.
// - Master driving data high during a detected start loses arbitration.
// - Clocked format: final bit received while rx-full sets overrun.
// - No-ack, stop, arbitration/overrun clear only by write 0 after reading 1.
// - Tx-done request when enabled, dropped by clearing flag or enable.
// - Format select: 0 two-wire, 1 clocked synchronous.
module iefs_flags
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Register port
  input  wire logic [1:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // Datapath events on this clock
  input  wire iefs_pkg::iefs_dp_ev_type dp,
  // Bus pins
  input  wire logic                   scl_pin,
  input  wire logic                   sda_pin,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Requests and transfer control
  output iefs_pkg::iefs_irq_type      irq,
  output logic                        halt_transfer
);

  typedef struct packed {
    logic [7:0]             ier;
    logic [7:0]             sr;
    logic [7:0]             ctrl;
    logic [7:0]             armed;
    logic                   frame_seen;
    logic [7:0]             rdata;
    iefs_pkg::iefs_irq_type irq;
    logic                   halt;
    logic                   sda_out;
    logic                   sda_oe;
  } iefs_state_type;

  iefs_state_type             st;
  iefs_state_type             next_st;
  iefs_pkg::iefs_link_ev_type lev;
  logic [1:0]                 pins_s;
  logic                       scl_s;
  logic                       sda_s;
  logic [7:0]                 flag_set;
  logic [7:0]                 flag_clr;
  logic                       fs;
  logic                       transmit_select;
  logic                       mst;

  function automatic logic hit(input logic [1:0] addr, input logic [1:0] target);
    hit = (addr == target);
  endfunction

  // ==========================================================================
  // Pin sampling and bus event detection
  iefs_sync2 u_sync
  (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .pin_in   ({scl_pin, sda_pin}),
    .pin_sync (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  iefs_bus_watch u_watch
  (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .scl_s         (scl_s),
    .sda_s         (sda_s),
    .format_select (fs),
    .lev           (lev)
  );

  assign fs  = st.ctrl[iefs_pkg::CTRL_FORMAT];
  assign transmit_select = st.ctrl[iefs_pkg::CTRL_TX_SEL];
  assign mst = st.ctrl[iefs_pkg::CTRL_MASTER];

  // ==========================================================================
  // Flag set and clear terms
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[iefs_pkg::SR_TX_EMPTY] = dp.tx_load || dp.start_issued || dp.slave_to_tx ||
      (reg_wr && hit(reg_addr, iefs_pkg::ADDR_CTRL) &&
       reg_wdata[iefs_pkg::CTRL_TX_SEL] && !transmit_select);
    flag_set[iefs_pkg::SR_TX_DONE] =
      (lev.ninth_rise && st.sr[iefs_pkg::SR_TX_EMPTY]) ||
      (fs && transmit_select && lev.final_rise);
    flag_set[iefs_pkg::SR_RX_FULL] = dp.rx_load;
    flag_set[iefs_pkg::SR_NO_ACK] = lev.ninth_rise && transmit_select && sda_s &&
      st.ier[iefs_pkg::IER_ACK_CHECK];
    flag_set[iefs_pkg::SR_STOP] = lev.stop && st.frame_seen;
    flag_set[iefs_pkg::SR_ARB_LOST] =
      (!fs && mst && transmit_select && lev.scl_rise && (dp.sda_drive != sda_s)) ||
      (!fs && mst && lev.start && dp.sda_drive) ||
      (fs && !transmit_select && lev.final_rise && st.sr[iefs_pkg::SR_RX_FULL]);
    flag_clr = 8'h00;
    // Software clear needs a prior read of 1; the arm is dropped by any status register write
    for (int i = 0; i < 8; i++)
    begin
      flag_clr[i] = reg_wr && hit(reg_addr, iefs_pkg::ADDR_SR) && !reg_wdata[i] &&
        st.armed[i];
    end
    flag_clr[iefs_pkg::SR_TX_EMPTY] = flag_clr[iefs_pkg::SR_TX_EMPTY] ||
      dp.tx_holding_write;
    flag_clr[iefs_pkg::SR_TX_DONE] = flag_clr[iefs_pkg::SR_TX_DONE] ||
      dp.tx_holding_write;
    flag_clr[iefs_pkg::SR_RX_FULL] = flag_clr[iefs_pkg::SR_RX_FULL] ||
      dp.rx_holding_read;
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_st = st;
    // A flag set in the same cycle as its clear survives
    next_st.sr = ((st.sr & ~flag_clr) | flag_set) & iefs_pkg::SR_FLAGS;
    if (reg_wr && hit(reg_addr, iefs_pkg::ADDR_IER))
    begin
      next_st.ier = (reg_wdata & iefs_pkg::IER_WMASK) |
        (st.ier & ~iefs_pkg::IER_WMASK);
    end
    if (reg_wr && hit(reg_addr, iefs_pkg::ADDR_CTRL))
    begin
      next_st.ctrl = reg_wdata & iefs_pkg::CTRL_MASK;
    end
    if (lev.ninth_rise && transmit_select)
    begin
      next_st.ier[iefs_pkg::IER_ACK_RECV] = sda_s;
    end
    if (reg_wr && hit(reg_addr, iefs_pkg::ADDR_SR))
    begin
      next_st.armed = 8'h00;
    end
    else if (reg_rd && hit(reg_addr, iefs_pkg::ADDR_SR))
    begin
      next_st.armed = st.armed | st.sr;
    end
    if (lev.ninth_rise || (fs && lev.final_rise))
    begin
      next_st.frame_seen = 1'b1;
    end
    else if (lev.stop)
    begin
      next_st.frame_seen = 1'b0;
    end
    next_st.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        iefs_pkg::ADDR_IER:
        begin
          next_st.rdata = st.ier & 8'h7F;
        end
        iefs_pkg::ADDR_SR:
        begin
          next_st.rdata = st.sr;
        end
        iefs_pkg::ADDR_CTRL:
        begin
          next_st.rdata = st.ctrl;
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
    // Requests follow the registered flags and enables as levels
    next_st.irq.rx_full_irq = next_st.sr[iefs_pkg::SR_RX_FULL] &&
      next_st.ier[iefs_pkg::IER_RX_IE];
    next_st.irq.error_irq = fs && next_st.sr[iefs_pkg::SR_ARB_LOST] &&
      (next_st.ier[iefs_pkg::IER_RX_IE] || next_st.ier[iefs_pkg::IER_NO_ACK_IE]);
    next_st.irq.no_ack_irq = next_st.ier[iefs_pkg::IER_NO_ACK_IE] &&
      (next_st.sr[iefs_pkg::SR_NO_ACK] ||
       (!fs && next_st.sr[iefs_pkg::SR_ARB_LOST]));
    next_st.irq.stop_irq = next_st.sr[iefs_pkg::SR_STOP] &&
      next_st.ier[iefs_pkg::IER_STOP_IE];
    next_st.irq.tx_done_irq = next_st.sr[iefs_pkg::SR_TX_DONE] &&
      next_st.ier[iefs_pkg::IER_TX_DONE_IE];
    // Halt is only meaningful while transmitting; ignored ack never halts
    next_st.halt = transmit_select && next_st.ier[iefs_pkg::IER_ACK_CHECK] &&
      next_st.ier[iefs_pkg::IER_ACK_RECV];
    next_st.sda_oe  = lev.ack_phase && !transmit_select && !fs;
    next_st.sda_out = st.ier[iefs_pkg::IER_ACK_TO_SEND];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st <= '{ier: iefs_pkg::IER_RESET, sr: iefs_pkg::SR_RESET,
              ctrl: iefs_pkg::CTRL_RESET, armed: 8'h00, frame_seen: 1'b0,
              rdata: 8'h00, irq: '0, halt: 1'b0, sda_out: 1'b1, sda_oe: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata     = st.rdata;
  assign irq           = st.irq;
  assign halt_transfer = st.halt;
  assign sda_out       = st.sda_out;
  assign sda_oe        = st.sda_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_sr_write_zero(int pos);
    reg_wr && hit(reg_addr, iefs_pkg::ADDR_SR) && !reg_wdata[pos];
  endsequence

  sequence s_sr_read;
    reg_rd && hit(reg_addr, iefs_pkg::ADDR_SR);
  endsequence

  chk_rx_full_set: assert property (dp.rx_load |=> st.sr[iefs_pkg::SR_RX_FULL])
    else $error("rx full flag missed a receive load");

  chk_rx_irq_gate: assert property (
    irq.rx_full_irq |-> st.ier[iefs_pkg::IER_RX_IE] && st.sr[iefs_pkg::SR_RX_FULL])
    else $error("rx full request without flag and enable");

  chk_no_ack_irq: assert property (
    irq.no_ack_irq |-> st.ier[iefs_pkg::IER_NO_ACK_IE] &&
      (st.sr[iefs_pkg::SR_NO_ACK] || st.sr[iefs_pkg::SR_ARB_LOST]))
    else $error("no ack request without cause");

  chk_stop_irq_en: assert property (
    !st.ier[iefs_pkg::IER_STOP_IE] |-> !irq.stop_irq)
    else $error("stop request while disabled");

  chk_ack_capture: assert property (
    lev.ninth_rise && transmit_select |=> st.ier[iefs_pkg::IER_ACK_RECV] == $past(sda_s))
    else $error("returned ack not captured");

  chk_ack_drive: assert property (
    sda_oe |-> !fs && !transmit_select && $past(lev.ack_phase))
    else $error("data driven outside ack slot");

  chk_tx_empty_clr: assert property (
    dp.tx_holding_write && !flag_set[iefs_pkg::SR_TX_EMPTY] |=> !st.sr[iefs_pkg::SR_TX_EMPTY])
    else $error("tx empty not cleared by holding write");

  chk_sticky_no_ack: assert property (
    $fell(st.sr[iefs_pkg::SR_NO_ACK]) |-> $past(flag_clr[iefs_pkg::SR_NO_ACK]))
    else $error("no ack flag cleared without software");

  chk_read_clear: assert property (
    s_sr_read ##0 st.sr[iefs_pkg::SR_STOP]
      ##1 (st.sr[iefs_pkg::SR_STOP] && !lev.stop && !reg_rd && !reg_wr)
      ##1 s_sr_write_zero(iefs_pkg::SR_STOP) ##0 !flag_set[iefs_pkg::SR_STOP]
      |=> !st.sr[iefs_pkg::SR_STOP])
    else $error("stop flag not cleared after read then write zero");

  chk_al_start: assert property (
    !fs && mst && lev.start && dp.sda_drive |=> st.sr[iefs_pkg::SR_ARB_LOST])
    else $error("arbitration loss at start missed");

  chk_tx_done_irq: assert property (
    $rose(irq.tx_done_irq) |-> st.ier[iefs_pkg::IER_TX_DONE_IE] && st.sr[iefs_pkg::SR_TX_DONE])
    else $error("tx done request without cause");

  // ==========================================================================
  // Flag setting, clearing and request level checks
  chk_tx_empty_set: assert property (
    dp.tx_load || dp.start_issued || dp.slave_to_tx |=> st.sr[iefs_pkg::SR_TX_EMPTY])
    else $error("tx empty not set by its cause");

  chk_tx_done_set: assert property (
    (lev.ninth_rise && st.sr[iefs_pkg::SR_TX_EMPTY]) || (fs && transmit_select && lev.final_rise)
      |=> st.sr[iefs_pkg::SR_TX_DONE])
    else $error("tx done not set at end of frame");

  chk_tx_done_clr: assert property (
    dp.tx_holding_write && !flag_set[iefs_pkg::SR_TX_DONE] |=> !st.sr[iefs_pkg::SR_TX_DONE])
    else $error("tx done not cleared by holding write");

  chk_rx_full_clr: assert property (
    dp.rx_holding_read && !dp.rx_load |=> !st.sr[iefs_pkg::SR_RX_FULL])
    else $error("rx full not cleared by holding read");

  chk_no_ack_set: assert property (
    lev.ninth_rise && transmit_select && sda_s && st.ier[iefs_pkg::IER_ACK_CHECK]
      |=> st.sr[iefs_pkg::SR_NO_ACK])
    else $error("no ack flag missed a refused byte");

  chk_stop_set: assert property (
    lev.stop && st.frame_seen |=> st.sr[iefs_pkg::SR_STOP])
    else $error("stop flag missed a stop after a frame");

  chk_arb_mismatch: assert property (
    !fs && mst && transmit_select && lev.scl_rise && (dp.sda_drive != sda_s)
      |=> st.sr[iefs_pkg::SR_ARB_LOST])
    else $error("arbitration loss on data mismatch missed");

  chk_overrun_set: assert property (
    fs && !transmit_select && lev.final_rise && st.sr[iefs_pkg::SR_RX_FULL]
      |=> st.sr[iefs_pkg::SR_ARB_LOST])
    else $error("overrun missed on last bit while rx full");

  chk_error_irq: assert property (
    irq.error_irq |-> st.sr[iefs_pkg::SR_ARB_LOST] &&
      (st.ier[iefs_pkg::IER_RX_IE] || st.ier[iefs_pkg::IER_NO_ACK_IE]))
    else $error("error request without overrun and enable");

  chk_halt_level: assert property (
    halt_transfer |-> st.ier[iefs_pkg::IER_ACK_CHECK] && st.ier[iefs_pkg::IER_ACK_RECV])
    else $error("halt without ack check and refused ack");

  chk_ack_recv_ro: assert property (
    reg_wr && hit(reg_addr, iefs_pkg::ADDR_IER) && !(lev.ninth_rise && transmit_select)
      |=> st.ier[iefs_pkg::IER_ACK_RECV] == $past(st.ier[iefs_pkg::IER_ACK_RECV]))
    else $error("received ack bit changed by software");

  chk_tx_done_drop: assert property (
    !st.sr[iefs_pkg::SR_TX_DONE] || !st.ier[iefs_pkg::IER_TX_DONE_IE] |-> !irq.tx_done_irq)
    else $error("tx done request held after flag or enable cleared");

  chk_sticky_stop: assert property (
    $fell(st.sr[iefs_pkg::SR_STOP]) |-> $past(flag_clr[iefs_pkg::SR_STOP]))
    else $error("stop flag cleared without software");

endmodule

// File: bench/iefs_far_model.sv
`timescale 1ns/1ns
module iefs_far_model
(
  // Bus lines: clock driven both ways, data open drain with pull-up outside
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line,
  // Level found on the data line in the ack slot
  output logic      ack_seen
);
  // ==========================================================================
  // Idle bus: clock stands high, data released
  initial
  begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    ack_seen = 1'b0;
  end

  task automatic start_cond();
    #2;
    sda_low = 1'b1;
    #62;
    scl = 1'b0;
    #62;
  endtask

  // Bits change only while the clock is low; without an ack the line is released with the clock high, which can show a stop
  task automatic send_bits(input logic [7:0] d, input int n, input logic with_ack);
    #2;
    for (int i = 0; i < n; i++)
    begin
      scl = 1'b0;
      #30;
      sda_low = ~d[7-i];
      #32;
      scl = 1'b1;
      #63;
    end
    if (with_ack)
    begin
      scl = 1'b0;
      #30;
      sda_low = 1'b0;
      #32;
      scl = 1'b1;
      #30;
      ack_seen = sda_line;
      #33;
      scl = 1'b0;
    end
    else
      sda_low = 1'b0;
  endtask

  task automatic stop_cond();
    #2;
    sda_low = 1'b1;
    #62;
    scl = 1'b1;
    #62;
    sda_low = 1'b0;
    #62;
  endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [1:0] wa;
    logic [7:0] wd;
    logic [6:0] ev;
    logic [1:0] ra;
    logic [7:0] exp_data;
    logic [4:0] exp_irq;
  } iefs_row_type;

  logic                     clk_sys;
  logic                     rstn;
  logic [1:0]               reg_addr;
  logic [7:0]               reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [7:0]               reg_rdata;
  iefs_pkg::iefs_dp_ev_type dp;
  iefs_pkg::iefs_irq_type   irq;
  logic                     sda_out;
  logic                     sda_oe;
  logic                     halt_transfer;
  logic                     scl_line;
  logic                     sda_low;
  logic                     ack_seen;
  wire                      sda_line;
  int                       err_count;
  int                       comparisons;
  logic [7:0]               v;

  // Pull-up: the line is low only while some party pulls it down
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  iefs_flags dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dp(dp), .scl_pin(scl_line), .sda_pin(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq), .halt_transfer(halt_transfer));

  iefs_far_model far_u (.scl(scl_line), .sda_low(sda_low), .sda_line(sda_line),
    .ack_seen(ack_seen));

  // Write, dp pulse, read back: register data and request levels
  iefs_row_type rows [16] = '{
    '{2'h0, 8'hFF, 7'h00, 2'h0, 8'h7D, 5'h00},
    '{2'h2, 8'hFF, 7'h00, 2'h2, 8'h07, 5'h00},
    '{2'h3, 8'hFF, 7'h00, 2'h3, 8'h00, 5'h00},
    '{2'h2, 8'h00, 7'h04, 2'h1, 8'h00, 5'h00},
    '{2'h2, 8'h00, 7'h40, 2'h1, 8'h80, 5'h00},
    '{2'h2, 8'h00, 7'h04, 2'h1, 8'h00, 5'h00},
    '{2'h2, 8'h00, 7'h10, 2'h1, 8'h80, 5'h00},
    '{2'h1, 8'h00, 7'h00, 2'h1, 8'h00, 5'h00},
    '{2'h2, 8'h00, 7'h08, 2'h1, 8'h80, 5'h00},
    '{2'h2, 8'h00, 7'h04, 2'h1, 8'h00, 5'h00},
    '{2'h2, 8'h02, 7'h00, 2'h1, 8'h80, 5'h00},
    '{2'h2, 8'h02, 7'h04, 2'h1, 8'h00, 5'h00},
    '{2'h2, 8'h00, 7'h20, 2'h1, 8'h20, 5'h10},
    '{2'h2, 8'h00, 7'h02, 2'h1, 8'h00, 5'h00},
    '{2'h0, 8'h5D, 7'h20, 2'h1, 8'h20, 5'h00},
    '{2'h0, 8'h7D, 7'h00, 2'h1, 8'h20, 5'h10}
  };

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge clk_sys);
    dp <= iefs_pkg::iefs_dp_ev_type'(dp | m);
    @(posedge clk_sys);
    dp <= iefs_pkg::iefs_dp_ev_type'(dp & ~m);
  endtask

  // Pins pass two stages and a watcher before flags move
  task automatic sr_chk(input logic [7:0] e, input logic [4:0] ei);
    repeat (6) @(posedge clk_sys);
    rd(iefs_pkg::ADDR_SR, v);
    chk("status", v, e);
    chk("requests", {3'h0, irq}, {3'h0, ei});
  endtask

  task automatic clr_all();
    rd(iefs_pkg::ADDR_SR, v);
    wr(iefs_pkg::ADDR_SR, 8'h00);
  endtask

  task automatic finish_test();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Whole run is well under 40 us; this only cuts a hang
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    err_count   = 0;
    comparisons = 0;
    rstn        = 1'b0;
    reg_addr    = 2'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    dp          = '0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      if (rows[i].ev != 7'h00)
        pulse(rows[i].ev);
      rd(rows[i].ra, v);
      chk("row data", v, rows[i].exp_data);
      chk("row requests", {3'h0, irq}, {3'h0, rows[i].exp_irq});
    end
    // Clocked format: last bit lands while the receive flag is still up
    wr(iefs_pkg::ADDR_CTRL, 8'h01);
    far_u.send_bits(8'h3C, 8, 1'b0);
    sr_chk(8'h24, 5'h18);
    wr(iefs_pkg::ADDR_SR, 8'h00);
    pulse(7'h20);
    wr(iefs_pkg::ADDR_SR, 8'h00);
    sr_chk(8'h20, 5'h10);
    wr(iefs_pkg::ADDR_SR, 8'h00);
    sr_chk(8'h00, 5'h00);
    // Transmit frame refused by the far side, stop request held off
    wr(iefs_pkg::ADDR_CTRL, 8'h02);
    wr(iefs_pkg::ADDR_IER, 8'h75);
    far_u.start_cond();
    far_u.send_bits(8'hA5, 8, 1'b1);
    sr_chk(8'hD0, 5'h05);
    rd(iefs_pkg::ADDR_IER, v);
    chk("enable reg", v, 8'h77);
    chk("halt", {7'h0, halt_transfer}, 8'h01);
    far_u.stop_cond();
    sr_chk(8'hD8, 5'h05);
    wr(iefs_pkg::ADDR_IER, 8'h7D);
    sr_chk(8'hD8, 5'h07);
    wr(iefs_pkg::ADDR_SR, 8'h00);
    sr_chk(8'h00, 5'h00);
    wr(iefs_pkg::ADDR_IER, 8'h79);
    @(posedge clk_sys);
    #1;
    chk("halt", {7'h0, halt_transfer}, 8'h00);
    // Receive mode: both ack levels driven in the slot
    wr(iefs_pkg::ADDR_CTRL, 8'h00);
    for (int a = 0; a < 2; a++)
    begin
      wr(iefs_pkg::ADDR_IER, 8'h7C | 8'(a));
      far_u.start_cond();
      far_u.send_bits(8'h96, 8, 1'b1);
      far_u.stop_cond();
      chk("ack level", {7'h0, ack_seen}, 8'(a));
    end
    // Master holding data high while another party starts
    clr_all();
    wr(iefs_pkg::ADDR_CTRL, 8'h04);
    @(posedge clk_sys);
    dp.sda_drive <= 1'b1;
    far_u.start_cond();
    sr_chk(8'h04, 5'h04);
    far_u.stop_cond();
    clr_all();
    // Master transmit: the line shows a zero against a driven one
    wr(iefs_pkg::ADDR_CTRL, 8'h06);
    far_u.send_bits(8'h00, 1, 1'b0);
    sr_chk(8'h84, 5'h04);
    clr_all();
    // Clocked transmit: eight clocks from any count below eight hold one final bit
    wr(iefs_pkg::ADDR_CTRL, 8'h03);
    far_u.send_bits(8'hFF, 8, 1'b0);
    sr_chk(8'h40, 5'h01);
    clr_all();
    // Second reset in mid-run
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 0; a < 4; a++)
    begin
      rd(2'(a), v);
      chk("after reset", v, 8'h00);
    end
    chk("requests", {3'h0, irq}, 8'h00);
    chk("drive", {6'h0, halt_transfer, sda_oe}, 8'h00);
    finish_test();
  end
endmodule
